// *** serial_pkg.sv ***
// shared constants, types and helpers of the serial status and control block
package serial_pkg;
  // register byte offsets
  localparam logic [11:0] MODE_OFS   = 12'h3ac;
  localparam logic [11:0] STATUS_OFS = 12'h3b0;
  localparam logic [11:0] TXDATA_OFS = 12'h3b4;
  localparam logic [11:0] RXDATA_OFS = 12'h3b8;
  localparam logic [11:0] BAUD_OFS   = 12'h3bc;
  // status and control field positions
  localparam int TXM_HI_B = 15;
  localparam int TXPOL_B  = 14;
  localparam int TXM_LO_B = 13;
  localparam int RXEN_B   = 12;
  localparam int BRK_B    = 11;
  localparam int TXEN_B   = 10;
  localparam int RXM_B    = 6;
  localparam int ADET_B   = 5;
  localparam int OVR_B    = 1;
  // mode field positions
  localparam int PORTEN_B = 15;
  localparam int IRC_B    = 12;
  localparam int PDSEL_B  = 1;
  // reset values and writable bits
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'hfce0;
  localparam logic [15:0] MODE_RST   = 16'h0000;
  localparam logic [15:0] MODE_WMASK = 16'h9006;
  localparam logic [15:0] BAUD_RST   = 16'h0000;
  // interrupt mode codes
  localparam logic [1:0] TXM_ON_LOAD = 2'h0;
  localparam logic [1:0] TXM_DONE    = 2'h1;
  localparam logic [1:0] TXM_EMPTIED = 2'h2;
  localparam logic [1:0] RXM_3Q      = 2'h2;
  localparam logic [1:0] RXM_FULL    = 2'h3;
  localparam int         RX_3Q_CNT   = 3;
  // data format codes
  localparam logic [1:0] PDSEL_8N   = 2'h0;
  localparam logic [1:0] PDSEL_ODD  = 2'h2;
  localparam logic [1:0] PDSEL_9BIT = 2'h3;
  // timing in baud ticks and frame lengths in bits
  localparam logic [3:0]  LAST_SUB    = 4'hf;
  localparam logic [3:0]  MID_SUB     = 4'h7;
  localparam logic [13:0] BREAK_FRAME = 14'h2000;
  localparam logic [3:0]  BREAK_BITS  = 4'he;
  localparam logic [3:0]  FRAME_8N    = 4'ha;
  localparam logic [3:0]  FRAME_LONG  = 4'hb;

  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_e;

  // one buffered received character
  typedef struct packed {
    logic       frm_err;
    logic       par_err;
    logic [8:0] data;
  } rx_char_s;

  // parity bit for eight data bits in the given format
  function automatic logic parity_of(logic [7:0] d, logic [1:0] fmt);
    return (^d) ^ (fmt == PDSEL_ODD);
  endfunction

  // frame length from start bit to stop bit
  function automatic logic [3:0] frame_len(logic [1:0] fmt);
    return (fmt == PDSEL_8N) ? FRAME_8N : FRAME_LONG;
  endfunction
endpackage

// *** char_fifo.sv ***
// small character buffer with valid/ready on both sides and a registered head
module char_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2,
  parameter int PW    = $clog2(DEPTH)
) (
  // clock and reset
  input  logic             core_clk,
  input  logic             reset,
  input  logic             flush,
  // fill side
  input  logic             wr_valid,
  input  logic [WIDTH-1:0] wr_data,
  output logic             wr_ready,
  // drain side
  output logic             rd_valid,
  output logic [WIDTH-1:0] rd_data,
  input  logic             rd_ready,
  output logic [PW:0]      count
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [PW:0]      count_r;
  logic [WIDTH-1:0] head_r;

  // handshakes and next head
  assign wr_ready = !flush && (count_r != (PW+1)'(DEPTH));
  assign rd_valid = count_r != '0;
  wire              wr_fire    = wr_valid && wr_ready;
  wire              rd_fire    = rd_valid && rd_ready && !flush;
  wire [PW-1:0]     rd_ptr_nxt = rd_ptr_r + PW'(rd_fire);
  wire [WIDTH-1:0]  head_nxt   = (wr_fire && wr_ptr_r == rd_ptr_nxt) ? wr_data
                                                                      : mem_r[rd_ptr_nxt];
  assign rd_data = head_r;
  assign count   = count_r;

  // storage, no reset needed
  always_ff @(posedge core_clk) begin
    if (wr_fire) mem_r[wr_ptr_r] <= wr_data;
    head_r <= head_nxt;
  end

  // pointers and fill level
  always_ff @(posedge core_clk) begin
    if (reset || flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + PW'(wr_fire);
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_r + (PW+1)'(wr_fire) - (PW+1)'(rd_fire);
    end
  end
endmodule // char_fifo

// *** serial_status_control.sv ***
// serial port status and control register with its transmit and receive engines
// Behaviour
// RL1 - tx mode 10: event when a load into the shifter empties the buffer
// RL2 - tx mode 01: event when the last frame has shifted out, nothing queued
// RL3 - tx mode 00: event on every load of a character into the shifter
// RL4 - software never writes tx mode 11, it is reserved
// RL5 - idle polarity bit with codec on means idle high, codec off idle low
// RL6 - receive enable hands the receive pin to the port and receives
// RL7 - break request sends start, twelve zeros, stop, then clears itself
// RL8 - clearing transmit enable aborts, empties the buffer, releases the pin
// RL9 - buffer full flag is 1 only when no more character fits
// RL10 - shift empty flag is 1 when shifter and buffer are empty, resets 1
// RL11 - rx mode 11 fires at four held, 10 at three, 0x on any char
// RL12 - address detect in 9-bit mode keeps only characters with bit 8 set
// RL13 - receiver idle flag is 1 unless a character is being received
// RL14 - parity error flag belongs to the character at the buffer head
// RL15 - framing error flag belongs to the character at the buffer head
// RL16 - overrun set on overflow; clearing it empties buffer and receiver
// RL17 - data available flag is 1 while the receive buffer is not empty
// RL18 - character arriving with buffer full is dropped, reception halts until clear
module serial_status_control #(
  parameter int TX_DEPTH = 2,
  parameter int RX_DEPTH = 4
) (
  // clock and reset
  input  logic        core_clk,
  input  logic        reset,
  // apb slave
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [11:0] paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  // serial pins
  input  logic        rx_pin,
  output logic        tx_pin,
  output logic        tx_pin_oe_n,
  output logic        rx_pin_owned,
  // event pulses
  output logic        tx_irq,
  output logic        rx_irq
);
  localparam int TCW = $clog2(TX_DEPTH);
  localparam int RCW = $clog2(RX_DEPTH);

  logic [15:0] ctrl_r;
  logic [15:0] mode_r;
  logic [15:0] baud_div_r;
  logic [15:0] baud_cnt_r;
  logic        overrun_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        tx_line_r;
  logic        tx_oe_n_r;
  logic        rx_own_r;
  logic        tx_irq_r;
  logic        rx_irq_r;

  // apb decode, zero-wait access after each setup
  wire setup_c    = psel && !penable;
  wire access_c   = psel && penable && pready_r;
  wire wr_c       = access_c && pwrite;
  wire rd_c       = access_c && !pwrite;
  wire hit_mode   = paddr == serial_pkg::MODE_OFS;
  wire hit_status = paddr == serial_pkg::STATUS_OFS;
  wire hit_tx     = paddr == serial_pkg::TXDATA_OFS;
  wire hit_rx     = paddr == serial_pkg::RXDATA_OFS;
  wire hit_baud   = paddr == serial_pkg::BAUD_OFS;
  wire mapped     = hit_mode || hit_status || hit_tx || hit_rx || hit_baud;

  // control fields
  wire [1:0] tx_irq_mode       = {ctrl_r[serial_pkg::TXM_HI_B], ctrl_r[serial_pkg::TXM_LO_B]};
  wire       tx_idle_polarity  = ctrl_r[serial_pkg::TXPOL_B];
  wire       rx_enable         = ctrl_r[serial_pkg::RXEN_B];
  wire       send_break        = ctrl_r[serial_pkg::BRK_B];
  wire       tx_enable         = ctrl_r[serial_pkg::TXEN_B];
  wire [1:0] rx_irq_mode       = ctrl_r[serial_pkg::RXM_B +: 2];
  wire       address_detect_en = ctrl_r[serial_pkg::ADET_B];
  wire       port_enable       = mode_r[serial_pkg::PORTEN_B];
  wire       infrared_codec_en = mode_r[serial_pkg::IRC_B];
  wire [1:0] pdsel             = mode_r[serial_pkg::PDSEL_B +: 2];
  wire       nine_bit          = pdsel == serial_pkg::PDSEL_9BIT;
  wire       par_on            = !nine_bit && pdsel != serial_pkg::PDSEL_8N;
  wire       tx_on             = port_enable && tx_enable;
  wire       rx_on             = port_enable && rx_enable;

  // baud tick divider, one enable pulse per sixteenth of a bit
  wire tick = baud_cnt_r >= baud_div_r;
  always_ff @(posedge core_clk) begin
    if (reset || tick) baud_cnt_r <= 16'h0000;
    else baud_cnt_r <= baud_cnt_r + 16'h0001;
  end

  // ---------------- transmit ----------------
  serial_pkg::tx_state_e tx_state_r;
  logic [13:0]     tx_shift_r;
  logic [3:0]      tx_left_r;
  logic [3:0]      tx_sub_r;
  logic            tx_brk_frame_r;
  logic            txq_valid;
  logic [8:0]      txq_data;
  logic            txq_wr_ready;
  logic [TCW:0]    txq_count;

  // transmit sequencing terms
  wire        tx_idle     = tx_state_r == serial_pkg::TX_IDLE;
  wire        tx_break_go = tx_idle && tx_on && send_break;
  wire        tx_load     = tx_idle && tx_on && !send_break && txq_valid;
  wire        bit_end     = tick && tx_sub_r == serial_pkg::LAST_SUB;
  wire        frame_end   = !tx_idle && bit_end && tx_left_r == 4'h1;
  wire        brk_done    = frame_end && tx_brk_frame_r;
  wire        tx_par      = serial_pkg::parity_of(txq_data[7:0], pdsel);
  wire [13:0] tx_frame    = nine_bit ? {4'hf, txq_data, 1'b0}
                          : par_on   ? {4'hf, tx_par, txq_data[7:0], 1'b0}
                                     : {5'h1f, txq_data[7:0], 1'b0};
  // RL9 buffer full flag
  wire tx_full = txq_count == (TCW+1)'(TX_DEPTH);
  // RL10 shifter and buffer both empty
  wire tx_shift_empty = tx_idle && !txq_valid;

  // RL8 tx abort: disabling flushes the buffer
  char_fifo #(.WIDTH(9), .DEPTH(TX_DEPTH)) tx_buf (
    .core_clk (core_clk),
    .reset    (reset),
    .flush    (!tx_on),
    .wr_valid (wr_c && hit_tx),
    .wr_data  (pwdata[8:0]),
    .wr_ready (txq_wr_ready),
    .rd_valid (txq_valid),
    .rd_data  (txq_data),
    .rd_ready (tx_load),
    .count    (txq_count)
  );

  // frame shifter, lsb first, start bit at bit 0
  always_ff @(posedge core_clk) begin
    if (reset || !tx_on) begin
      tx_state_r     <= serial_pkg::TX_IDLE;
      tx_shift_r     <= '1;
      tx_left_r      <= 4'h0;
      tx_brk_frame_r <= 1'b0;
    // RL7 break frame
    end else if (tx_break_go) begin
      tx_state_r     <= serial_pkg::TX_SHIFT;
      tx_shift_r     <= serial_pkg::BREAK_FRAME;
      tx_left_r      <= serial_pkg::BREAK_BITS;
      tx_brk_frame_r <= 1'b1;
    end else if (tx_load) begin
      tx_state_r     <= serial_pkg::TX_SHIFT;
      tx_shift_r     <= tx_frame;
      tx_left_r      <= serial_pkg::frame_len(pdsel);
      tx_brk_frame_r <= 1'b0;
    end else if (!tx_idle && bit_end) begin
      tx_shift_r <= {1'b1, tx_shift_r[13:1]};
      tx_left_r  <= tx_left_r - 4'h1;
      if (tx_left_r == 4'h1) tx_state_r <= serial_pkg::TX_IDLE;
    end
  end

  // tick counter within the current bit
  always_ff @(posedge core_clk) begin
    if (reset || tx_idle) tx_sub_r <= 4'h0;
    else if (tick) tx_sub_r <= tx_sub_r + 4'h1;
  end

  // transmit event per mode
  wire txe_load  = tx_load && tx_irq_mode == serial_pkg::TXM_ON_LOAD;
  wire txe_empty = tx_load && tx_irq_mode == serial_pkg::TXM_EMPTIED
                   && txq_count == (TCW+1)'(1) && !(wr_c && hit_tx);
  wire txe_done  = frame_end && tx_irq_mode == serial_pkg::TXM_DONE && !txq_valid;
  // RL5 idle level from polarity and codec
  wire tx_invert = tx_idle_polarity ^ infrared_codec_en;

  // pin drive and transmit event
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_line_r <= 1'b1;
      tx_oe_n_r <= 1'b1;
      tx_irq_r  <= 1'b0;
    end else begin
      tx_line_r <= (tx_idle ? 1'b1 : tx_shift_r[0]) ^ tx_invert;
      // RL8 pin back to port when disabled
      tx_oe_n_r <= !tx_on;
      // RL1 RL2 RL3 transmit event modes
      tx_irq_r  <= txe_load || txe_empty || txe_done;
    end
  end

  // ---------------- receive ----------------
  logic [2:0]      rx_sync_r;
  logic            rx_lvl_r;
  serial_pkg::rx_state_e rx_state_r;
  logic [3:0]      rx_sub_r;
  logic [3:0]      rx_left_r;
  logic [10:0]     rx_shift_r;
  logic            rxq_valid;
  logic [10:0]     rxq_data;
  logic            rxq_wr_ready;
  logic [RCW:0]    rxq_count;

  // pin synchroniser; a change counts once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_sync_r <= 3'h7;
      rx_lvl_r  <= 1'b1;
    end else begin
      rx_sync_r <= {rx_sync_r[1:0], rx_pin};
      if (rx_sync_r[1] == rx_sync_r[2]) rx_lvl_r <= rx_sync_r[2];
    end
  end

  // received frame decoding, stop bit in bit 10
  wire        rx_done  = rx_state_r == serial_pkg::RX_BITS && tick
                         && rx_sub_r == serial_pkg::LAST_SUB && rx_left_r == 4'h1;
  wire [10:0] rx_word  = {rx_lvl_r, rx_shift_r[10:1]};
  wire [8:0]  rx_data9 = nine_bit ? rx_word[9:1]
                       : par_on   ? {1'b0, rx_word[8:1]} : {1'b0, rx_word[9:2]};
  wire        rx_parity_error  = par_on && rx_word[9] != serial_pkg::parity_of(rx_word[8:1], pdsel);
  // RL12 address filter in 9-bit mode
  wire        rx_keep  = !(address_detect_en && nine_bit && !rx_data9[8]);
  wire        rx_push  = rx_done && rx_keep && !overrun_r;
  // RL18 overflow drops the character
  wire        ovf_set  = rx_push && !rxq_wr_ready;
  // RL16 overrun clear on a 1 to 0 write
  wire        rx_clr   = wr_c && hit_status && overrun_r && !pwdata[serial_pkg::OVR_B];
  wire        rx_pop   = rd_c && hit_rx;
  wire [RCW:0] rx_after = rxq_count + (RCW+1)'(1) - (RCW+1)'(rxq_valid && rx_pop);
  serial_pkg::rx_char_s rx_in;
  serial_pkg::rx_char_s rx_head;
  assign rx_in   = '{frm_err: !rx_word[10], par_err: rx_parity_error, data: rx_data9};
  assign rx_head = serial_pkg::rx_char_s'(rxq_data);

  // four character receive buffer
  char_fifo #(.WIDTH(11), .DEPTH(RX_DEPTH)) rx_buf (
    .core_clk (core_clk),
    .reset    (reset),
    .flush    (rx_clr),
    .wr_valid (rx_push),
    .wr_data  (rx_in),
    .wr_ready (rxq_wr_ready),
    .rd_valid (rxq_valid),
    .rd_data  (rxq_data),
    .rd_ready (rx_pop),
    .count    (rxq_count)
  );

  // RL6 RL13 RL16 receiver sequencer, mid-bit sampling
  always_ff @(posedge core_clk) begin
    if (reset || !rx_on || rx_clr) begin
      rx_state_r <= serial_pkg::RX_IDLE;
      rx_sub_r   <= 4'h0;
      rx_left_r  <= 4'h0;
      rx_shift_r <= '1;
    end else begin
      unique case (rx_state_r)
        serial_pkg::RX_IDLE: begin
          rx_sub_r <= 4'h0;
          // RL18 halted while overrun stands
          if (!rx_lvl_r && !overrun_r) rx_state_r <= serial_pkg::RX_START;
        end
        serial_pkg::RX_START: if (tick) begin
          rx_sub_r <= rx_sub_r + 4'h1;
          if (rx_sub_r == serial_pkg::MID_SUB) begin
            rx_sub_r   <= 4'h0;
            rx_left_r  <= serial_pkg::frame_len(pdsel) - 4'h1;
            rx_state_r <= rx_lvl_r ? serial_pkg::RX_IDLE : serial_pkg::RX_BITS;
          end
        end
        serial_pkg::RX_BITS: if (tick) begin
          rx_sub_r <= rx_sub_r + 4'h1;
          if (rx_sub_r == serial_pkg::LAST_SUB) begin
            rx_shift_r <= rx_word;
            rx_left_r  <= rx_left_r - 4'h1;
            if (rx_left_r == 4'h1) rx_state_r <= serial_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  // RL11 receive event per mode
  wire rxe = (rx_irq_mode == serial_pkg::RXM_FULL) ? rx_after == (RCW+1)'(RX_DEPTH)
           : (rx_irq_mode == serial_pkg::RXM_3Q)   ? rx_after == (RCW+1)'(serial_pkg::RX_3Q_CNT)
                                                    : 1'b1;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_irq_r  <= 1'b0;
      rx_own_r  <= 1'b0;
      overrun_r <= 1'b0;
    end else begin
      rx_irq_r  <= rx_push && rxq_wr_ready && rxe;
      rx_own_r  <= rx_on;
      // RL16 set wins over clear
      overrun_r <= ovf_set || (overrun_r && !rx_clr);
    end
  end

  // ---------------- registers ----------------
  wire        rx_idle   = rx_state_r == serial_pkg::RX_IDLE;
  // RL14 RL15 RL17 head flags and data available
  wire [15:0] status_rd = {ctrl_r[15:10], tx_full, tx_shift_empty, ctrl_r[7:5], rx_idle,
                           rxq_valid && rx_head.par_err, rxq_valid && rx_head.frm_err,
                           overrun_r, rxq_valid};
  wire [31:0] rd_mux    = hit_mode   ? {16'h0000, mode_r}
                        : hit_status ? {16'h0000, status_rd}
                        : hit_rx     ? {23'h00_0000, rx_head.data}
                        : hit_baud   ? {16'h0000, baud_div_r} : 32'h0000_0000;

  // software writes; break request cleared by hardware when done
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_r     <= serial_pkg::CTRL_RST;
      mode_r     <= serial_pkg::MODE_RST;
      baud_div_r <= serial_pkg::BAUD_RST;
    end else begin
      if (wr_c && hit_status) ctrl_r <= pwdata[15:0] & serial_pkg::CTRL_WMASK;
      // RL7 break request self-clears
      else if (brk_done) ctrl_r[serial_pkg::BRK_B] <= 1'b0;
      if (wr_c && hit_mode) mode_r <= pwdata[15:0] & serial_pkg::MODE_WMASK;
      if (wr_c && hit_baud) baud_div_r <= pwdata[15:0];
    end
  end

  // apb answer one cycle after setup
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= setup_c;
      pslverr_r <= setup_c && !mapped;
      if (setup_c) prdata_r <= rd_mux;
    end
  end

  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign tx_pin       = tx_line_r;
  assign tx_pin_oe_n  = tx_oe_n_r;
  assign rx_pin_owned = rx_own_r;
  assign tx_irq       = tx_irq_r;
  assign rx_irq       = rx_irq_r;

  // ---------------- checks ----------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  tx_load_evt_a: assert property (txe_load |=> tx_irq_r) // RL3
    else $error("mode 00 load gave no transmit event");
  tx_empty_evt_a: assert property (tx_irq_r && $past(tx_irq_mode) == 2'h2 // RL1
    |-> $past(tx_load) && txq_count == '0) else $error("mode 10 event without emptying load");
  tx_done_evt_a: assert property (tx_irq_r && $past(tx_irq_mode) == 2'h1 // RL2
    |-> $past(frame_end) && tx_idle) else $error("mode 01 event before frame end");
  idle_level_a: assert property ($past(tx_idle) |-> tx_line_r == // RL5
    !($past(tx_idle_polarity) ^ $past(infrared_codec_en))) else $error("wrong idle level");
  break_frame_a: assert property (tx_break_go |=> tx_shift_r == 14'h2000 // RL7
    && tx_left_r == 4'he ##1 send_break) else $error("break frame not loaded");
  break_clear_a: assert property (brk_done && !(wr_c && hit_status) |=> !send_break) // RL7
    else $error("break request not cleared");
  tx_abort_a: assert property (!tx_on |=> tx_idle && txq_count == '0 && tx_oe_n_r) // RL8
    else $error("transmit not aborted");
  tx_shift_busy_a: assert property (tx_load ##1 tx_on |-> !tx_shift_empty [*2]) // RL10
    else $error("shift empty during frame");
  rx_full_evt_a: assert property (rx_irq_r && $past(rx_irq_mode) == 2'h3 // RL11
    |-> rxq_count == (RCW+1)'(RX_DEPTH)) else $error("mode 11 event before full");
  overrun_hold_a: assert property (ovf_set && !rx_pop |=> overrun_r // RL18
    && rxq_count == $past(rxq_count))
    else $error("overflow stored a character");
  overrun_clr_a: assert property (rx_clr |=> rxq_count == '0 && rx_idle && !overrun_r) // RL16
    else $error("overrun clear did not empty receiver");
  rx_release_a: assert property (!rx_on |=> !rx_own_r && rx_idle) // RL6
    else $error("receiver kept pin while disabled");

  break_sent_c: cover property (brk_done);
  overflow_c: cover property (ovf_set);
  rx_full_c: cover property (rx_irq_r && rx_irq_mode == 2'h3);
  tx_done_c: cover property (tx_irq_r && tx_irq_mode == 2'h1);
endmodule // serial_status_control

// *** serial_partner.sv ***
// remote serial transceiver model facing the port's pins
module serial_partner (
  // clock
  input  wire logic       core_clk,
  // serial lines
  input  wire logic       tx_line,
  output      logic       rx_line,
  // last frame captured from tx, stop bit on top
  output      logic [8:0] last_frame
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT = 16; // clocks per bit at divisor zero

  // idle line is high
  initial rx_line = 1'b1;

  // one 8N frame onto the receive line, lsb first
  task automatic send(input logic [7:0] d, input logic stop);
    rx_line <= 1'b0;
    repeat (BIT) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      rx_line <= d[i];
      repeat (BIT) @(posedge core_clk);
    end
    // a bad stop is held only past its sample point
    rx_line <= stop;
    repeat (12) @(posedge core_clk);
    rx_line <= 1'b1;
    repeat (2 * BIT) @(posedge core_clk);
  endtask

  // mid-bit capture of each transmitted frame
  initial begin
    forever begin
      @(negedge tx_line);
      repeat (BIT / 2) @(posedge core_clk);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT) @(posedge core_clk);
        last_frame <= {tx_line, last_frame[8:1]};
      end
    end
  end
endmodule // serial_partner

// *** serial_status_control_test.sv ***
// self-checking bench of the serial status and control block
module serial_status_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [11:0] a; logic [15:0] d; logic [15:0] x; logic e;} row_s;
  logic        core_clk, reset, psel, penable, pwrite, pready, pslverr, rerr;
  logic        rx_pin, tx_pin, tx_pin_oe_n, rx_pin_owned, tx_irq, rx_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [8:0]  frame;
  logic [15:0] txm [3] = '{16'h0400, 16'h2400, 16'h8400};
  int          tx_ev [3] = '{3, 1, 2};
  int          fail_count, num_checks, tcnt, rcnt, n;
  row_s        rows [4] = '{'{serial_pkg::STATUS_OFS, 16'h0040, 16'h0150, 1'b0},
                            '{serial_pkg::STATUS_OFS, 16'h2020, 16'h2130, 1'b0},
                            '{serial_pkg::MODE_OFS, 16'h0006, 16'h0006, 1'b0},
                            '{12'h3c0, 16'h1234, 16'h0000, 1'b1}};

  serial_status_control dut (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .tx_pin_oe_n(tx_pin_oe_n), .rx_pin_owned(rx_pin_owned),
    .tx_irq(tx_irq), .rx_irq(rx_irq));
  serial_partner p (.core_clk(core_clk), .tx_line(tx_pin), .rx_line(rx_pin),
    .last_frame(frame));

  // 100 ns clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // event pulse counters
  always @(posedge core_clk) begin
    if (tx_irq === 1'b1) tcnt++;
    if (rx_irq === 1'b1) rcnt++;
  end

  // one apb transfer, request held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1 && ++k < 20);
    if (pready !== 1'b1) fail_count++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stat(input logic [15:0] x);
    apb(1'b0, serial_pkg::STATUS_OFS, 16'h0000);
    chk(rdat[15:0], x);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // hang guard far beyond the expected run
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    print_verdict;
  end

  // main sequence
  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    chk(tx_pin_oe_n, 1'b1);
    chk(rx_pin_owned, 1'b0);
    stat(16'h0110);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 16'h0000);
      chk(rdat[15:0], rows[i].x);
      chk(rerr, rows[i].e);
    end
    apb(1'b1, serial_pkg::MODE_OFS, 16'h8000);
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, serial_pkg::STATUS_OFS, txm[m]);
      tcnt = 0;
      for (int k = 0; k < 3; k++) apb(1'b1, serial_pkg::TXDATA_OFS, 16'h0030 + 16'(3 * m + k));
      stat(txm[m] | 16'h0210);
      n = 0;
      do apb(1'b0, serial_pkg::STATUS_OFS, 16'h0000); while (rdat[8] !== 1'b1 && ++n < 300);
      if (rdat[8] !== 1'b1) fail_count++;
      repeat (4) @(posedge core_clk);
      chk(tcnt, tx_ev[m]);
      chk(frame, {1'b1, 8'h32 + 8'(3 * m)});
    end
    apb(1'b1, serial_pkg::STATUS_OFS, 16'h0c00);
    n = 0;
    while (tx_pin !== 1'b0 && n++ < 50) @(posedge core_clk);
    n = 0;
    while (tx_pin === 1'b0 && n < 400) begin
      @(posedge core_clk);
      n++;
    end
    chk(n, 208);
    // let the stop bit finish before the self-clear is checked
    repeat (16) @(posedge core_clk);
    stat(16'h0510);
    apb(1'b1, serial_pkg::STATUS_OFS, 16'h4400);
    repeat (2) @(posedge core_clk);
    chk(tx_pin, 1'b0);
    chk(tx_pin_oe_n, 1'b0);
    apb(1'b1, serial_pkg::MODE_OFS, 16'h9000);
    repeat (2) @(posedge core_clk);
    chk(tx_pin, 1'b1);
    apb(1'b1, serial_pkg::MODE_OFS, 16'h8000);
    apb(1'b1, serial_pkg::STATUS_OFS, 16'h10c0);
    repeat (2) @(posedge core_clk);
    chk(rx_pin_owned, 1'b1);
    chk(tx_pin_oe_n, 1'b1);
    rcnt = 0;
    for (int k = 0; k < 5; k++) p.send(8'h61 + 8'(k), k != 1);
    repeat (20) @(posedge core_clk);
    chk(rcnt, 1);
    stat(16'h11d3);
    apb(1'b0, serial_pkg::RXDATA_OFS, 16'h0000);
    chk(rdat[15:0], 16'h0061);
    stat(16'h11d7);
    apb(1'b1, serial_pkg::STATUS_OFS, 16'h10c0);
    stat(16'h11d0);
    // parity error at the head, then address filter in 9-bit mode
    apb(1'b1, serial_pkg::MODE_OFS, 16'h8002);
    p.send(8'h61, 1'b0);
    stat(16'h11d9);
    apb(1'b0, serial_pkg::RXDATA_OFS, 16'h0000);
    chk(rdat[15:0], 16'h0061);
    apb(1'b1, serial_pkg::MODE_OFS, 16'h8006);
    apb(1'b1, serial_pkg::STATUS_OFS, 16'h1020);
    rcnt = 0;
    p.send(8'h55, 1'b0);
    p.send(8'h66, 1'b1);
    chk(rcnt, 1);
    apb(1'b0, serial_pkg::RXDATA_OFS, 16'h0000);
    chk(rdat[15:0], 16'h0166);
    print_verdict;
  end
endmodule // serial_status_control_test
